/* sim/kpi_keypad_model.sv */
`default_nettype none
module kpi_keypad_model
(
  // key presses from the bench
  input  wire logic [7:0] i_press,
  // port lines
  output logic      [7:0] o_keypad_lines
);
  timeunit 1ns;
  timeprecision 1ns;
  // a pressed key pulls its line low, pull-ups hold the rest high
  assign o_keypad_lines = ~i_press;
endmodule // kpi_keypad_model
`default_nettype wire

/* sim/tb_kpi_keypad_level_interrupt.sv */
`default_nettype none
module tb_kpi_keypad_level_interrupt;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
  logic       clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, glob = 1'b0, irq, wake;
  logic [7:0] addr = 8'h00, wdata = 8'h00, press = 8'h00, rdata, lines;
  int         fails = 0, checks_done = 0;
  // columns: level select, line enable, pressed keys, global enable, then expected flags, irq and wake;
  // high-select bits flag at once since idle lines sit high, and flags stay set
  logic [7:0] rows [4][7] = '{'{8'h00, 8'hff, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01},
                              '{8'h00, 8'hfe, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00},
                              '{8'h80, 8'h80, 8'h00, 8'h00, 8'h80, 8'h00, 8'h01},
                              '{8'h00, 8'h0f, 8'hf0, 8'h01, 8'hf0, 8'h00, 8'h00}};
  initial
  begin
    forever #10 clk = ~clk;
  end
  kpi_keypad_model kpi_keypad_model_inst (.i_press(press), .o_keypad_lines(lines));
  kpi_keypad_level_interrupt kpi_keypad_level_interrupt_inst (.i_ref_clk(clk), .i_srst(srst),
    .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata),
    .i_keypad_global_irq_enable(glob), .i_keypad_lines(lines), .o_keypad_irq(irq), .o_keypad_wake(wake));
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    {addr, rd} <= {a, 1'b1};
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK("rdata", e, rdata)
    // return on a rising edge so the next drive lands on one too
    @(posedge clk);
  endtask
  task automatic do_rst();
    {srst, press, glob} <= {1'b1, 8'h00, 1'b0};
    repeat (3) @(posedge clk);
    srst <= 1'b0;
  endtask
  task automatic end_sim();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ==========================================================
  // table cases, then clear, unmapped and reset cases
  initial
  begin
    foreach (rows[i])
    begin
      do_rst();
      wr_reg(kpi_pkg::KPI_ADDR_LEVEL_SELECT, rows[i][0]);
      wr_reg(kpi_pkg::KPI_ADDR_LINE_ENABLE, rows[i][1]);
      {press, glob} <= {rows[i][2], rows[i][3][0]};
      repeat (5) @(posedge clk);
      #1 `CHK("irq", rows[i][5][0], irq)
      `CHK("wake", rows[i][6][0], wake)
      rd_chk(kpi_pkg::KPI_ADDR_LINE_FLAGS, rows[i][4]);
    end
    wr_reg(kpi_pkg::KPI_ADDR_LINE_FLAGS, 8'h00);
    rd_chk(kpi_pkg::KPI_ADDR_LINE_FLAGS, 8'hf0);
    press <= 8'h00;
    repeat (4) @(posedge clk);
    rd_chk(kpi_pkg::KPI_ADDR_LINE_FLAGS, 8'hf0);
    wr_reg(kpi_pkg::KPI_ADDR_LINE_FLAGS, 8'h00);
    rd_chk(kpi_pkg::KPI_ADDR_LINE_FLAGS, 8'h00);
    rd_chk(8'h9f, 8'h00);
    wr_reg(kpi_pkg::KPI_ADDR_LEVEL_SELECT, 8'hff);
    do_rst();
    for (int a = 0; a < 3; a++)
      rd_chk(kpi_pkg::KPI_ADDR_LEVEL_SELECT + 8'(a), kpi_pkg::KPI_RESET_VALUE);
    `CHK("wake", 1'b0, wake)
    end_sim();
  end
endmodule // tb_kpi_keypad_level_interrupt
`default_nettype wire

/* verilog/kpi_keypad_level_interrupt.sv */
`default_nettype none
// Behaviour
// - Each of eight flag bits is set by hardware whenever its port line shows the level selected for it.
// - A set flag requests the keypad interrupt only while its line enable bit is one.
// - With its enable bit zero a line stays an ordinary pin and its flag requests nothing.
// - With its enable bit one the line's flag may raise the keypad interrupt request.
// - Level-select zero makes a low level the flag-setting condition.
// - Level-select one makes a high level the flag-setting condition.
// - After reset the flag, enable and level-select registers all read zero.
// - The eight lines share one request, gated by one global keypad enable bit.
// - Without the global enable the request is masked whatever the line enables are.
// - A detected enabled level raises a wake-up output usable in idle and power-down.
module kpi_keypad_level_interrupt
(
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_srst,
  // sfr bus from the core
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic       i_sfr_wr,
  input  wire logic       i_sfr_rd,
  input  wire logic [7:0] i_sfr_wdata,
  output logic      [7:0] o_sfr_rdata,
  // global gate from the second interrupt enable register
  input  wire logic       i_keypad_global_irq_enable,
  // keypad port lines
  input  wire logic [7:0] i_keypad_lines,
  // requests to the core
  output logic            o_keypad_irq,
  output logic            o_keypad_wake
);

  typedef struct packed
  {
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] keypad_level_select;
    logic [7:0] keypad_line_enable;
    logic [7:0] keypad_line_flags;
    logic [7:0] rdata;
    logic       irq;
    logic       wake;
    logic [1:0] primed;
  } kpi_state_type;

  kpi_state_type state;
  kpi_state_type next_state;
  logic [7:0]    hit;
  logic [7:0]    next_flags;

  // ============================================================
  // per-line level detection
  genvar g;
  generate
    for (g = 0; g < kpi_pkg::KPI_LINES; g++)
    begin : g_line
      // select zero matches low, select one matches high; the sync flops clear to zero
      // on reset, which would read as a held low line, so primed holds detection off
      // until a real pin sample has reached sync2
      assign hit[g] = state.primed[1] & ~(state.sync2[g] ^ state.keypad_level_select[g]);
    end
  endgenerate

  // ============================================================
  // next state
  always_comb
  begin
    next_state       = state;
    next_state.sync1 = i_keypad_lines;
    next_state.sync2 = state.sync1;
    // ones shift in after reset; bit 1 marks sync2 as holding a real sample
    next_state.primed = {state.primed[0], 1'b1};
    next_flags       = state.keypad_line_flags;
    if (i_sfr_wr && i_sfr_addr == kpi_pkg::KPI_ADDR_LEVEL_SELECT)
    begin
      next_state.keypad_level_select = i_sfr_wdata;
    end
    if (i_sfr_wr && i_sfr_addr == kpi_pkg::KPI_ADDR_LINE_ENABLE)
    begin
      next_state.keypad_line_enable = i_sfr_wdata;
    end
    // software write loads i_sfr_wdata; hardware set applied after so it wins
    if (i_sfr_wr && i_sfr_addr == kpi_pkg::KPI_ADDR_LINE_FLAGS)
    begin
      next_flags = i_sfr_wdata;
    end
    next_flags                   = next_flags | hit;
    next_state.keypad_line_flags = next_flags;
    // request follows registered flags; lines with enable zero drop out
    next_state.irq  = i_keypad_global_irq_enable
                      && |(state.keypad_line_flags & state.keypad_line_enable);
    // wake does not depend on the global gate, so power-down can exit
    next_state.wake = |(state.keypad_line_flags & state.keypad_line_enable);
    case (i_sfr_addr)
      kpi_pkg::KPI_ADDR_LEVEL_SELECT: next_state.rdata = state.keypad_level_select;
      kpi_pkg::KPI_ADDR_LINE_ENABLE:  next_state.rdata = state.keypad_line_enable;
      kpi_pkg::KPI_ADDR_LINE_FLAGS:   next_state.rdata = state.keypad_line_flags;
      default:                        next_state.rdata = 8'h00;
    endcase
    if (!i_sfr_rd)
    begin
      next_state.rdata = 8'h00;
    end
    if (i_srst)
    begin
      // clears the sync flops and primed as well
      next_state                     = '0;
      next_state.keypad_level_select = kpi_pkg::KPI_RESET_VALUE;
      next_state.keypad_line_enable  = kpi_pkg::KPI_RESET_VALUE;
      next_state.keypad_line_flags   = kpi_pkg::KPI_RESET_VALUE;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    state <= next_state;
  end

  assign o_sfr_rdata   = state.rdata;
  assign o_keypad_irq  = state.irq;
  assign o_keypad_wake = state.wake;

  // ============================================================
  // register checks
  AST_WR_LEVEL_SELECT: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    i_sfr_wr && i_sfr_addr == kpi_pkg::KPI_ADDR_LEVEL_SELECT |=> state.keypad_level_select == $past(i_sfr_wdata))
    else $error("level select write lost");

  AST_WR_LINE_ENABLE: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    i_sfr_wr && i_sfr_addr == kpi_pkg::KPI_ADDR_LINE_ENABLE |=> state.keypad_line_enable == $past(i_sfr_wdata))
    else $error("line enable write lost");

  AST_RD_FLAGS: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    i_sfr_rd && i_sfr_addr == kpi_pkg::KPI_ADDR_LINE_FLAGS |=> o_sfr_rdata == $past(state.keypad_line_flags))
    else $error("flag read returned wrong data");

  AST_RD_ENABLE: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    i_sfr_rd && i_sfr_addr == kpi_pkg::KPI_ADDR_LINE_ENABLE |=> o_sfr_rdata == $past(state.keypad_line_enable))
    else $error("enable read returned wrong data");

  AST_RD_SELECT: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    i_sfr_rd && i_sfr_addr == kpi_pkg::KPI_ADDR_LEVEL_SELECT |=> o_sfr_rdata == $past(state.keypad_level_select))
    else $error("level select read returned wrong data");

  AST_RESET_ZERO: assert property (@(posedge i_ref_clk)
    i_srst |=> state.keypad_line_flags == 8'h00 && state.keypad_line_enable == 8'h00
    && state.keypad_level_select == 8'h00)
    else $error("registers not zero after reset");

  AST_RESET_OUTPUTS: assert property (@(posedge i_ref_clk)
    i_srst |=> !o_keypad_irq && !o_keypad_wake && o_sfr_rdata == 8'h00)
    else $error("outputs not quiet after reset");

  // ============================================================
  // detection checks
  AST_FLAG_SET: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    !$past(i_srst) && hit[0] |=> state.keypad_line_flags[0])
    else $error("flag 0 not set after matching level");

  AST_FLAG_STICKY: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    !(i_sfr_wr && i_sfr_addr == kpi_pkg::KPI_ADDR_LINE_FLAGS)
    |=> (state.keypad_line_flags & $past(state.keypad_line_flags)) == $past(state.keypad_line_flags))
    else $error("flag cleared without software write");

  AST_FLAG_REARM: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    i_sfr_wr && i_sfr_addr == kpi_pkg::KPI_ADDR_LINE_FLAGS
    |=> state.keypad_line_flags == ($past(i_sfr_wdata) | $past(hit)))
    else $error("matching level did not win over a flag clear");

  AST_LOW_LEVEL: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    state.primed[1]
    |=> (~$past(state.keypad_level_select) & ~$past(state.sync2) & ~state.keypad_line_flags) == 8'h00)
    else $error("low level not detected");

  AST_HIGH_LEVEL: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    state.primed[1]
    |=> ($past(state.keypad_level_select) & $past(state.sync2) & ~state.keypad_line_flags) == 8'h00)
    else $error("high level not detected");

  AST_SYNC_DELAY: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    !i_keypad_lines[0] ##2 (state.primed[1] && !state.keypad_level_select[0]) |=> state.keypad_line_flags[0])
    else $error("held low line not flagged after sync");

  AST_RESET_SETTLE: assert property (@(posedge i_ref_clk)
    i_srst ##1 (!i_srst && !i_sfr_wr) |=> state.keypad_line_flags == 8'h00)
    else $error("flag set before line samples were valid");

  // ============================================================
  // request checks
  AST_IRQ_CAUSE: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_keypad_irq |-> $past(i_keypad_global_irq_enable)
    && ($past(state.keypad_line_flags) & $past(state.keypad_line_enable)) != 8'h00)
    else $error("irq without enabled flag");

  AST_IRQ_RAISE: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    i_keypad_global_irq_enable && (state.keypad_line_flags & state.keypad_line_enable) != 8'h00
    |=> o_keypad_irq)
    else $error("enabled flag did not raise irq");

  AST_GLOBAL_MASK: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    !i_keypad_global_irq_enable |=> !o_keypad_irq)
    else $error("irq while global enable low");

  AST_DISABLED_LINE: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    state.keypad_line_enable == 8'h00 |=> !o_keypad_irq && !o_keypad_wake)
    else $error("disabled lines raised a request");

  AST_NO_CAUSE_QUIET: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (state.keypad_line_flags & state.keypad_line_enable) == 8'h00 |=> !o_keypad_irq && !o_keypad_wake)
    else $error("request without an enabled flag");

  AST_WAKE_RAISE: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (state.keypad_line_flags & state.keypad_line_enable) != 8'h00 |=> o_keypad_wake)
    else $error("enabled flag did not raise wake");

  AST_WAKE_CAUSE: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_keypad_wake
    |-> ($past(state.keypad_line_flags) & $past(state.keypad_line_enable)) != 8'h00)
    else $error("wake without enabled flag");

endmodule // kpi_keypad_level_interrupt
`default_nettype wire

/* verilog/kpi_pkg.sv */
`default_nettype none
package kpi_pkg;
  // special function register addresses on the core's sfr bus
  localparam logic [7:0] KPI_ADDR_LEVEL_SELECT = 8'h9c;
  localparam logic [7:0] KPI_ADDR_LINE_ENABLE  = 8'h9d;
  localparam logic [7:0] KPI_ADDR_LINE_FLAGS   = 8'h9e;
  localparam int         KPI_LINES             = 8;
  localparam logic [7:0] KPI_RESET_VALUE       = 8'h00;
endpackage
`default_nettype wire
